// file: design/uff_pkg.sv
// uff_pkg: constants, types and decode helpers for the serial port front end.
// assumes a single 20 MHz core clock; the host bus and line pins are asynchronous to it.
package uff_pkg;

   // ==========================================================
   // register addresses on the three address pins
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER  = 3'h1;
   localparam logic [2:0] ADDR_FCR  = 3'h2;
   localparam logic [2:0] ADDR_LSR  = 3'h5;

   // ==========================================================
   // field positions and reset values
   localparam int          IER_RX      = 0;
   localparam int          IER_THR     = 1;
   localparam int          IER_LS      = 2;
   localparam int          IER_MS      = 3;
   localparam int          IER_SLEEP   = 4;
   localparam int          IER_XOFF    = 5;
   localparam int          IER_RTS     = 6;
   localparam int          IER_CTS     = 7;
   localparam int          FCR_EN      = 0;
   localparam int          FCR_RXRST   = 1;
   localparam int          FCR_TXRST   = 2;
   localparam int          FCR_DMA     = 3;
   localparam int          FCR_TRIG_LO = 6;
   localparam logic [7:0]  IER_RST     = 8'h00;
   localparam logic [1:0]  TRIG_RST    = 2'h0;

   // interrupt status codes, bits 5:0; bit 0 set means nothing pending
   localparam logic [5:0]  ISR_NONE    = 6'h01;
   localparam logic [5:0]  ISR_LS      = 6'h06;
   localparam logic [5:0]  ISR_RX      = 6'h04;
   localparam logic [5:0]  ISR_THR     = 6'h02;
   localparam logic [5:0]  ISR_MS      = 6'h00;
   localparam logic [5:0]  ISR_XOFF    = 6'h10;
   localparam logic [5:0]  ISR_CTSRTS  = 6'h20;

   // ==========================================================
   // timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int BAUD_RATE       = 115_200;
   localparam int OVERSAMPLE      = 16;
   localparam int BAUD_DIV        = CLK_HZ / (OVERSAMPLE * BAUD_RATE);
   localparam int START_MID_TICKS = 7;
   localparam int FIFO_DEPTH      = 16;

   // ==========================================================
   // types
   typedef struct packed {
      logic       frame_err;
      logic [7:0] data;
   } uff_rx_char_s;

   typedef struct packed {
      logic       cs;
      logic       rd;
      logic       wr;
      logic [2:0] addr;
      logic [7:0] data;
   } uff_bus_s;

   // trigger code to byte count
   function automatic logic [4:0] uff_trig_level(input logic [1:0] code);
      case (code)
         2'h0:    uff_trig_level = 5'h01;
         2'h1:    uff_trig_level = 5'h04;
         2'h2:    uff_trig_level = 5'h08;
         default: uff_trig_level = 5'h0e;
      endcase
   endfunction

endpackage

// file: design/uff_fifo.sv
// uff_fifo: flip-flop FIFO with flush, used for both directions.
// assumes push is never given when full and pop never when empty.
`timescale 1ns/1ps
module uff_fifo
   import uff_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = FIFO_DEPTH,
   parameter int AW    = $clog2(DEPTH),
   parameter int CW    = $clog2(DEPTH + 1)
)(
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   input  wire logic          flush,
   input  wire logic          push,
   input  wire logic [W-1:0]  push_data,
   input  wire logic          pop,
   output logic      [W-1:0]  pop_data,
   output logic      [CW-1:0] count,
   output logic               full,
   output logic               empty
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
   } uff_fifo_s;

   uff_fifo_s st_q;
   uff_fifo_s st_d;

   assign pop_data = st_q.mem[st_q.rp];
   assign count    = st_q.cnt;
   assign full     = (st_q.cnt == CW'(DEPTH));
   assign empty    = (st_q.cnt == '0);

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wp] = push_data;
         st_d.wp           = (st_q.wp == AW'(DEPTH - 1)) ? '0 : st_q.wp + 1'b1;
      end
      if (pop) begin
         st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : st_q.rp + 1'b1;
      end
      st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
      // flush resets pointers and count only; storage contents are left stale
      if (flush) begin
         st_d.wp  = '0;
         st_d.rp  = '0;
         st_d.cnt = '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// file: design/uff_rx_shift.sv
// uff_rx_shift: receive shift stage with false-start rejection, 8 data bits, one stop.
// assumes rx_line is already synchronised and tick pulses at 16x the bit rate.
`timescale 1ns/1ps
module uff_rx_shift
   import uff_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   rst_b,
   input  wire logic   tick,
   input  wire logic   rx_line,
   output logic        char_valid,
   output uff_rx_char_s char_out
);

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } uff_rx_state_e;

   typedef struct packed {
      uff_rx_state_e state;
      logic          prev;
      logic [3:0]    cnt;
      logic [2:0]    bits;
      logic [7:0]    sh;
      logic          valid;
      uff_rx_char_s  chr;
   } uff_rx_s;

   uff_rx_s st_q;
   uff_rx_s st_d;

   assign char_valid = st_q.valid;
   assign char_out   = st_q.chr;

   always_comb begin
      st_d       = st_q;
      st_d.prev  = rx_line;
      st_d.valid = 1'b0;
      case (st_q.state)
         RX_IDLE: begin
            if (st_q.prev && !rx_line) begin
               st_d.state = RX_START;
               st_d.cnt   = '0;
            end
         end
         RX_START: begin
            if (tick) begin
               st_d.cnt = st_q.cnt + 1'b1;
               // middle of the start bit: a glitch that has gone high is dropped
               if (st_q.cnt == 4'(START_MID_TICKS)) begin
                  st_d.state = rx_line ? RX_IDLE : RX_DATA;
                  st_d.cnt   = '0;
                  st_d.bits  = '0;
               end
            end
         end
         RX_DATA: begin
            if (tick) begin
               st_d.cnt = st_q.cnt + 1'b1;
               if (st_q.cnt == 4'hf) begin
                  st_d.sh   = {rx_line, st_q.sh[7:1]};
                  st_d.bits = st_q.bits + 1'b1;
                  if (st_q.bits == 3'h7) begin
                     st_d.state = RX_STOP;
                  end
               end
            end
         end
         RX_STOP: begin
            if (tick) begin
               st_d.cnt = st_q.cnt + 1'b1;
               if (st_q.cnt == 4'hf) begin
                  st_d.valid         = 1'b1;
                  st_d.chr.data      = st_q.sh;
                  st_d.chr.frame_err = !rx_line;
                  st_d.state         = RX_IDLE;
               end
            end
         end
         default: begin
            st_d.state = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q       <= '0;
         st_q.prev  <= 1'b1;
         st_q.state <= RX_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// file: design/uff_front.sv
// uff_front: host bus front end of the serial port: holding FIFOs, interrupt enables,
// trigger levels, line status and the two ready-signalling modes.
// assumes an asynchronous strobed parallel bus; bus, rx and cts pins are synchronised before use, rts_req, xoff_seen and modem_change are not.
`timescale 1ns/1ps
module uff_front
   import uff_pkg::*;
#(
   parameter int BAUD_DIVISOR = BAUD_DIV,
   parameter int DEPTH        = FIFO_DEPTH
)(
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] addr_pin,
   input  wire logic       cs_b,
   input  wire logic       ior_b,
   input  wire logic       iow_b,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_b,
   input  wire logic       rx_pin,
   output logic            tx_pin,
   input  wire logic       cts_b,
   input  wire logic       rts_req,
   output logic            rts_b,
   input  wire logic       xoff_seen,
   input  wire logic       modem_change,
   output logic            int_out,
   output logic            transmit_ready_out_b,
   output logic            receive_ready_out_b,
   output logic            sleep_mode
);

   localparam int CW = $clog2(DEPTH + 1);
   localparam int DW = $clog2(BAUD_DIVISOR + 1);

   // ==========================================================
   // state
   typedef struct packed {
      uff_bus_s   bus1;
      uff_bus_s   bus2;
      logic       rd_prev;
      logic       wr_prev;
      logic       rx1;
      logic       rx2;
      logic       cts1;
      logic       cts2;
      logic       cts_prev;
      logic       rts_pin;
      logic [7:0] interrupt_enable;
      logic       fifo_en;
      logic       dma_mode;
      logic [1:0] trig;
      logic [DW-1:0] div;
      logic       overrun;
      logic       data_err;
      logic       pend_cts;
      logic       pend_rts;
      logic       pend_xoff;
      logic       pend_ls;
      logic       receive_ready_out_act;
      logic [7:0] rdata;
      logic       tx_busy;
      logic [9:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_cnt;
      logic       tx_line;
   } uff_front_s;

   uff_front_s st_q;
   uff_front_s st_d;

   // ==========================================================
   // datapath instances
   logic          tick;
   logic          rx_valid;
   uff_rx_char_s  rx_char;
   uff_rx_char_s  rx_head;
   logic [CW-1:0] rx_count;
   logic          rx_full;
   logic          rx_empty;
   logic [7:0]    tx_head;
   logic [CW-1:0] tx_count;
   logic          tx_full;
   logic          tx_empty;
   logic          rx_push;
   logic          rx_pop;
   logic          tx_push;
   logic          tx_pop;
   logic          rx_flush;
   logic          tx_flush;

   uff_rx_shift u_rx (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .tick       (tick),
      .rx_line    (st_q.rx2),
      .char_valid (rx_valid),
      .char_out   (rx_char)
   );

   uff_fifo #(.W(9), .DEPTH(DEPTH)) u_rx_fifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .flush     (rx_flush),
      .push      (rx_push),
      .push_data (rx_char),
      .pop       (rx_pop),
      .pop_data  (rx_head),
      .count     (rx_count),
      .full      (rx_full),
      .empty     (rx_empty)
   );

   uff_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .flush     (tx_flush),
      .push      (tx_push),
      .push_data (st_q.bus2.data),
      .pop       (tx_pop),
      .pop_data  (tx_head),
      .count     (tx_count),
      .full      (tx_full),
      .empty     (tx_empty)
   );

   // ==========================================================
   // decode and status
   logic          rd_edge;
   logic          wr_edge;
   logic          rx_cap_full;
   logic          tx_cap_full;
   logic          trig_hit;
   logic          fcr_wr;
   logic [CW-1:0] trig_cnt;
   logic [7:0]    line_status;
   logic [5:0]    isr_code;
   logic          int_rx;
   logic          int_thr;
   logic          int_ls;
   logic          int_ms;
   logic          int_xoff;
   logic          int_cr;

   assign rd_edge  = st_q.bus2.cs && st_q.bus2.rd && !st_q.rd_prev;
   assign wr_edge  = st_q.bus2.cs && st_q.bus2.wr && !st_q.wr_prev;
   assign tick     = (st_q.div == DW'(BAUD_DIVISOR - 1));
   assign trig_cnt = CW'(uff_trig_level(st_q.trig));
   // with FIFOs off each direction holds a single character
   assign rx_cap_full = st_q.fifo_en ? rx_full : !rx_empty;
   assign tx_cap_full = st_q.fifo_en ? tx_full : !tx_empty;
   assign trig_hit    = st_q.fifo_en ? (rx_count >= trig_cnt) : !rx_empty;
   assign fcr_wr      = wr_edge && (st_q.bus2.addr == ADDR_FCR) && st_q.bus2.data[FCR_EN];

   assign rx_push  = rx_valid && !rx_cap_full;
   assign rx_pop   = rd_edge && (st_q.bus2.addr == ADDR_DATA) && !rx_empty;
   assign tx_push  = wr_edge && (st_q.bus2.addr == ADDR_DATA) && !tx_cap_full;
   assign tx_pop   = !st_q.tx_busy && !tx_empty;
   assign rx_flush = fcr_wr && st_q.bus2.data[FCR_RXRST];
   assign tx_flush = fcr_wr && st_q.bus2.data[FCR_TXRST];

   // line status; parity and break are not checked by this receiver
   assign line_status[0] = !rx_empty;
   assign line_status[1] = st_q.overrun;
   assign line_status[2] = 1'b0;
   assign line_status[3] = !rx_empty && rx_head.frame_err;
   assign line_status[4] = 1'b0;
   assign line_status[5] = tx_empty;
   assign line_status[6] = tx_empty && !st_q.tx_busy;
   assign line_status[7] = st_q.data_err;

   assign int_ls   = st_q.interrupt_enable[IER_LS] && st_q.pend_ls;
   assign int_rx   = st_q.interrupt_enable[IER_RX] && trig_hit;
   // block mode raises the transmit source while any location is free
   assign int_thr  = st_q.interrupt_enable[IER_THR] && (st_q.dma_mode ? !tx_full : tx_empty);
   assign int_ms   = st_q.interrupt_enable[IER_MS] && modem_change;
   assign int_xoff = st_q.interrupt_enable[IER_XOFF] && st_q.pend_xoff;
   assign int_cr   = (st_q.interrupt_enable[IER_CTS] && st_q.pend_cts) || (st_q.interrupt_enable[IER_RTS] && st_q.pend_rts);

   always_comb begin
      if (int_ls) begin
         isr_code = ISR_LS;
      end else if (int_rx) begin
         isr_code = ISR_RX;
      end else if (int_thr) begin
         isr_code = ISR_THR;
      end else if (int_ms) begin
         isr_code = ISR_MS;
      end else if (int_xoff) begin
         isr_code = ISR_XOFF;
      end else if (int_cr) begin
         isr_code = ISR_CTSRTS;
      end else begin
         isr_code = ISR_NONE;
      end
   end

   assign int_out    = int_ls | int_rx | int_thr | int_ms | int_xoff | int_cr;
   assign sleep_mode = st_q.interrupt_enable[IER_SLEEP];
   assign data_out   = st_q.rdata;
   assign data_oe_b  = !(st_q.bus2.cs && st_q.bus2.rd);
   assign tx_pin     = st_q.tx_line;
   assign rts_b      = st_q.rts_pin;
   // mode 1 transmit ready is high only when full; mode 0 high once anything is loaded
   assign transmit_ready_out_b = (st_q.fifo_en && st_q.dma_mode) ? tx_full
                                                                 : !(tx_empty && !st_q.tx_busy);
   assign receive_ready_out_b  = (st_q.fifo_en && st_q.dma_mode) ? !st_q.receive_ready_out_act : rx_empty;

   // ==========================================================
   // next state
   always_comb begin
      st_d          = st_q;
      st_d.bus1     = '{cs: !cs_b, rd: !ior_b, wr: !iow_b, addr: addr_pin, data: data_in};
      st_d.bus2     = st_q.bus1;
      st_d.rd_prev  = st_q.bus2.cs && st_q.bus2.rd;
      st_d.wr_prev  = st_q.bus2.cs && st_q.bus2.wr;
      st_d.rx1      = rx_pin;
      st_d.rx2      = st_q.rx1;
      st_d.cts1     = cts_b;
      st_d.cts2     = st_q.cts1;
      st_d.cts_prev = st_q.cts2;
      st_d.rts_pin  = !rts_req;
      st_d.div      = tick ? '0 : st_q.div + 1'b1;

      // reads: clears happen first so a same-cycle event below still sets
      if (rd_edge) begin
         case (st_q.bus2.addr)
            ADDR_DATA: st_d.rdata = rx_empty ? 8'h00 : rx_head.data;
            ADDR_IER:  st_d.rdata = st_q.interrupt_enable;
            ADDR_FCR:  st_d.rdata = {st_q.fifo_en, st_q.fifo_en, isr_code};
            ADDR_LSR:  st_d.rdata = line_status;
            default:   st_d.rdata = 8'h00;
         endcase
         if (st_q.bus2.addr == ADDR_LSR) begin
            st_d.overrun  = 1'b0;
            st_d.data_err = 1'b0;
            st_d.pend_ls  = 1'b0;
         end
         if (st_q.bus2.addr == ADDR_FCR) begin
            // reading status retires only the source it reported
            if (isr_code == ISR_XOFF) begin
               st_d.pend_xoff = 1'b0;
            end
            if (isr_code == ISR_CTSRTS) begin
               st_d.pend_cts = 1'b0;
               st_d.pend_rts = 1'b0;
            end
         end
      end

      // writes
      if (wr_edge && (st_q.bus2.addr == ADDR_IER)) begin
         st_d.interrupt_enable = st_q.bus2.data;
      end
      if (wr_edge && (st_q.bus2.addr == ADDR_FCR)) begin
         st_d.fifo_en = st_q.bus2.data[FCR_EN];
         if (st_q.bus2.data[FCR_EN]) begin
            st_d.dma_mode = st_q.bus2.data[FCR_DMA];
            st_d.trig     = st_q.bus2.data[FCR_TRIG_LO +: 2];
         end
      end

      // events from the line and neighbouring logic
      if (st_q.cts2 && !st_q.cts_prev) begin
         st_d.pend_cts = 1'b1;
      end
      if (!rts_req && !st_q.rts_pin) begin
         st_d.pend_rts = 1'b1;
      end
      if (xoff_seen) begin
         st_d.pend_xoff = 1'b1;
      end
      if (rx_push) begin
         st_d.pend_ls = 1'b1;
         if (rx_char.frame_err) begin
            st_d.data_err = 1'b1;
         end
      end
      if (rx_valid && rx_cap_full) begin
         st_d.overrun = 1'b1;
      end

      // block-mode receive ready holds from trigger until the FIFO drains
      if (rx_count >= trig_cnt) begin
         st_d.receive_ready_out_act = 1'b1;
      end else if (rx_empty) begin
         st_d.receive_ready_out_act = 1'b0;
      end

      // transmit shift stage: start bit, 8 data bits, stop bit
      if (tx_pop) begin
         st_d.tx_busy = 1'b1;
         st_d.tx_sh   = {1'b1, tx_head, 1'b0};
         st_d.tx_bits = '0;
         st_d.tx_cnt  = '0;
      end else if (st_q.tx_busy && tick) begin
         st_d.tx_cnt = st_q.tx_cnt + 1'b1;
         if (st_q.tx_cnt == 4'hf) begin
            st_d.tx_sh   = {1'b1, st_q.tx_sh[9:1]};
            st_d.tx_bits = st_q.tx_bits + 1'b1;
            if (st_q.tx_bits == 4'h9) begin
               st_d.tx_busy = 1'b0;
            end
         end
      end
      st_d.tx_line = st_d.tx_busy ? st_d.tx_sh[0] : 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q          <= '0;
         st_q.rx1      <= 1'b1;
         st_q.rx2      <= 1'b1;
         st_q.cts1     <= 1'b1;
         st_q.cts2     <= 1'b1;
         st_q.cts_prev <= 1'b1;
         st_q.rts_pin  <= 1'b1;
         st_q.interrupt_enable      <= IER_RST;
         st_q.trig     <= TRIG_RST;
         st_q.tx_line  <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// file: dv/uff_front_props.sv
// checker: pin timing of the front end
// assumes bus pins stay steady for a whole strobe
`timescale 1ns/1ps
module uff_front_props
   import uff_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst_b,
   input wire logic [2:0] addr_pin,
   input wire logic       cs_b,
   input wire logic       ior_b,
   input wire logic       iow_b,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_b,
   input wire logic       tx_pin,
   input wire logic       cts_b,
   input wire logic       rts_b,
   input wire logic       xoff_seen,
   input wire logic       modem_change,
   input wire logic       int_out,
   input wire logic       receive_ready_out_b,
   input wire logic       sleep_mode
);
   // ==========
   // enable mirror; only trusted once the bus has been quiet a while
   logic       wr_q;
   logic [2:0] a_q;
   logic [7:0] d_q;
   logic [7:0] ier_q;
   logic [2:0] quiet_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q    <= 1'b0;
         a_q     <= 3'h0;
         d_q     <= 8'h00;
         ier_q   <= IER_RST;
         quiet_q <= 3'h0;
      end else begin
         wr_q    <= !cs_b && !iow_b;
         a_q     <= addr_pin;
         d_q     <= data_in;
         if (wr_q && iow_b && a_q == ADDR_IER) begin
            ier_q <= d_q;
         end
         quiet_q <= !iow_b ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
      end
   end
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ==========
   // assertions
   reset_idle_a: assert property ($rose(rst_b) |-> tx_pin && !int_out && receive_ready_out_b && !sleep_mode)
      else $error("pins not idle after reset");
   bus_drive_a: assert property (!data_oe_b |-> !$past(cs_b, 2) && !$past(ior_b, 2))
      else $error("data bus driven without a read");
   rd_data_a: assert property ($changed(data_out) |-> !$past(ior_b, 3) && !$past(cs_b, 3))
      else $error("read data changed without a read");
   tx_start_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
      else $error("short low on serial out");
   sleep_bit_a: assert property (quiet_q == 3'h7 |-> sleep_mode == ier_q[IER_SLEEP])
      else $error("sleep output differs from enable bit");
   mask_all_a: assert property (quiet_q == 3'h7 && ier_q == 8'h00 |-> !int_out)
      else $error("interrupt with all sources masked");
   cts_int_a: assert property (quiet_q == 3'h7 && ier_q[IER_CTS] && $rose(cts_b) |-> ##[1:4] int_out)
      else $error("no interrupt on clear-to-send rise");
   rts_int_a: assert property (quiet_q == 3'h7 && ier_q[IER_RTS] && $rose(rts_b) |-> ##[0:3] int_out)
      else $error("no interrupt on request-to-send rise");
   xoff_int_a: assert property (quiet_q == 3'h7 && ier_q[IER_XOFF] && xoff_seen |-> ##[0:3] int_out)
      else $error("no interrupt on stop character");
   modem_int_a: assert property (quiet_q == 3'h7 && ier_q[IER_MS] && modem_change |-> ##[0:3] int_out)
      else $error("no interrupt on modem change");
endmodule
bind uff_front uff_front_props uff_front_props_i (.core_clk, .rst_b, .addr_pin, .cs_b, .ior_b, .iow_b, .data_in,
   .data_out, .data_oe_b, .tx_pin, .cts_b, .rts_b, .xoff_seen, .modem_change, .int_out, .receive_ready_out_b,
   .sleep_mode);

// file: dv/uff_host_model.sv
// host model: strobed bus master and serial line sender
// assumes pins change on the falling clock edge
`timescale 1ns/1ps
module uff_host_model #(
   parameter int BIT = 32
)(
   input  wire logic       core_clk,
   input  wire logic [7:0] data_out,
   output logic      [2:0] addr_pin,
   output logic            cs_b,
   output logic            ior_b,
   output logic            iow_b,
   output logic      [7:0] data_in,
   output logic            rx_pin
);
   event       got_ev;
   logic [7:0] got;
   initial begin
      addr_pin = 3'h0;
      cs_b = 1'b1;
      ior_b = 1'b1;
      iow_b = 1'b1;
      data_in = 8'h00;
      rx_pin = 1'b1;
   end
   // ==========
   // strobe low five cycles, high three: the synchroniser needs three of each
   task automatic access(input logic [2:0] a, input logic w, input logic [7:0] d);
      @(negedge core_clk);
      addr_pin = a;
      data_in = d;
      cs_b = 1'b0;
      iow_b = !w;
      ior_b = w;
      repeat (5) @(negedge core_clk);
      got = data_out;
      if (!w) begin
         ->got_ev;
      end
      cs_b = 1'b1;
      iow_b = 1'b1;
      ior_b = 1'b1;
      data_in = ~d;
      repeat (3) @(negedge core_clk);
   endtask
   task automatic frame(input logic [9:0] f, input int n, input int len);
      @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
         rx_pin = f[i];
         repeat (len) @(negedge core_clk);
      end
      rx_pin = 1'b1;
   endtask
endmodule

// file: dv/uff_front_test.sv
// bench: host bus and serial traffic through the model, reads checked in order
// assumes a 2-cycle tick, so one serial bit lasts 32 cycles
`timescale 1ns/1ps
module uff_front_test;
   import uff_pkg::*;
   localparam int BIT = 32;
   logic core_clk, rst_b, cs_b, ior_b, iow_b, rx_pin, cts_b, rts_req, xoff_seen, modem_change;
   logic data_oe_b, tx_pin, rts_b, int_out, transmit_ready_out_b, receive_ready_out_b, sleep_mode;
   logic [2:0] addr_pin;
   logic [7:0] data_in, data_out, r;
   logic [7:0] exp_q[$], rxq[$];
   int bad_count, checks_done;
   int lvl[4] = '{1, 4, 8, 14};
   logic [7:0] src[4] = '{8'h80, 8'h40, 8'h20, 8'h08};
   uff_front #(.BAUD_DIVISOR(2)) uff_front_i (.core_clk, .rst_b, .addr_pin, .cs_b, .ior_b, .iow_b, .data_in,
      .data_out, .data_oe_b, .rx_pin, .tx_pin, .cts_b, .rts_req, .rts_b, .xoff_seen, .modem_change, .int_out,
      .transmit_ready_out_b, .receive_ready_out_b, .sleep_mode);
   uff_host_model #(.BIT(BIT)) uff_host_model_i (.core_clk, .data_out, .addr_pin, .cs_b, .ior_b, .iow_b,
      .data_in, .rx_pin);
   always #25 core_clk = ~core_clk;
   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      uff_host_model_i.access(a, 1'b1, d);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      uff_host_model_i.access(a, 1'b0, 8'h00);
   endtask
   task automatic rx(input logic [7:0] c);
      uff_host_model_i.frame({1'b1, c, 1'b0}, 10, BIT);
      rxq.push_back(c);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(uff_host_model_i.got_ev) check("read", exp_q.pop_front(), uff_host_model_i.got);
   initial begin
      #2_500_000;
      bad_count++;
      results();
   end
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      cts_b = 1'b1;
      rts_req = 1'b0;
      xoff_seen = 1'b0;
      modem_change = 1'b0;
      bad_count = 0;
      checks_done = 0;
      r = 8'($urandom(34010));
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      check("idle", 8'h08, {4'h0, receive_ready_out_b, transmit_ready_out_b, sleep_mode, int_out});
      rd(ADDR_IER, IER_RST);
      rd(ADDR_LSR, 8'h60);
      rd(3'h7, 8'h00);
      r = 8'($urandom);
      wr(ADDR_IER, r);
      rd(ADDR_IER, r);
      check("sleep", {7'h0, r[IER_SLEEP]}, {7'h0, sleep_mode});
      wr(ADDR_IER, 8'h00);
      uff_host_model_i.frame(10'h000, 1, 6);
      repeat (BIT) @(negedge core_clk);
      rd(ADDR_LSR, 8'h60);
      rx(8'($urandom));
      check("rx ready", 8'h00, {7'h0, receive_ready_out_b});
      rd(ADDR_LSR, 8'h61);
      rd(ADDR_DATA, rxq.pop_front());
      check("rx ready", 8'h01, {7'h0, receive_ready_out_b});
      $display("registers and receive done");
      wr(ADDR_IER, 8'h01);
      for (int t = 0; t < 4; t++) begin
         wr(ADDR_FCR, {2'(t), 6'h07});
         for (int i = 0; i < lvl[t]; i++) begin
            check("rx int", 8'h00, {7'h0, int_out});
            rx(8'($urandom));
         end
         check("rx int", 8'h01, {7'h0, int_out});
         rd(ADDR_FCR, {2'h3, ISR_RX});
         while (rxq.size() > 0) begin
            rd(ADDR_DATA, rxq.pop_front());
            check("rx int", 8'h00, {7'h0, int_out});
         end
      end
      $display("trigger levels done");
      wr(ADDR_IER, 8'h02);
      r = 8'($urandom);
      wr(ADDR_DATA, r);
      wr(ADDR_DATA, 8'($urandom));
      check("tx ready", 8'h01, {7'h0, transmit_ready_out_b});
      check("tx int", 8'h00, {7'h0, int_out});
      // one bit later the line sits in the middle of the first data bit
      repeat (BIT) @(negedge core_clk);
      check("tx bit", {7'h0, r[0]}, {7'h0, tx_pin});
      repeat (BIT * 21) @(negedge core_clk);
      check("tx int", 8'h01, {7'h0, int_out});
      rd(ADDR_LSR, 8'h60);
      wr(ADDR_FCR, 8'h0f);
      for (int i = 0; i < 17; i++) begin
         wr(ADDR_DATA, 8'($urandom));
      end
      check("tx ready", 8'h01, {7'h0, transmit_ready_out_b});
      check("tx int", 8'h00, {7'h0, int_out});
      repeat (BIT * 11) @(negedge core_clk);
      check("tx ready", 8'h00, {7'h0, transmit_ready_out_b});
      check("tx int", 8'h01, {7'h0, int_out});
      repeat (BIT * 170) @(negedge core_clk);
      rd(ADDR_LSR, 8'h60);
      $display("transmit done");
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_IER, src[s]);
         repeat (4) @(negedge core_clk);
         cts_b = (s != 0);
         rts_req = (s == 1);
         xoff_seen = (s == 2);
         modem_change = (s == 3);
         @(negedge core_clk);
         xoff_seen = 1'b0;
         repeat (4) @(negedge core_clk);
         cts_b = 1'b1;
         rts_req = 1'b0;
         repeat (6) @(negedge core_clk);
         check("event int", 8'h01, {7'h0, int_out});
         modem_change = 1'b0;
         wr(ADDR_IER, 8'h00);
         check("event int", 8'h00, {7'h0, int_out});
      end
      rd(ADDR_LSR, 8'h60);
      $display("event interrupts done");
      results();
   end
endmodule
